// ===== hw/eaw_pkg.sv
/*
 * constants shared by the extended address window register block:
 * register numbers, configuration field positions, step modes,
 * address spaces, response status codes and timing counts.
 * assumes a 250 MHz system clock and deframed host packets.
 */
package eaw_pkg;

    // ------------------------------------------------------------
    // register numbers of the command interface
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CFG_AUTO = 8'h09;
    localparam logic [7:0] REG_LOW_AUTO = 8'h0a;
    localparam logic [7:0] REG_WIN_AUTO = 8'h0b;
    localparam logic [7:0] REG_CFG_GEN  = 8'h0e;
    localparam logic [7:0] REG_LOW_GEN  = 8'h0f;
    localparam logic [7:0] REG_WIN_GEN  = 8'h10;
    localparam logic [7:0] REG_LAST     = 8'h13;

    // ------------------------------------------------------------
    // configuration register fields
    // ------------------------------------------------------------
    localparam int RSTEP_HI  = 15;
    localparam int RSTEP_LO  = 14;
    localparam int WSTEP_HI  = 13;
    localparam int WSTEP_LO  = 12;
    localparam int SPACE_HI  = 11;
    localparam int SPACE_LO  = 9;
    localparam int STEP_HI   = 8;
    localparam int STEP_LO   = 7;
    localparam int HIADDR_HI = 5;
    localparam logic [15:0] RSVD_MASK = 16'h0040;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] LOW_RESET = 16'h0000;

    // step modes and address spaces
    typedef enum logic [1:0] {
        EAW_STEP_HOLD  = 2'h0,
        EAW_STEP_INC   = 2'h1,
        EAW_STEP_DEC   = 2'h2,
        EAW_STEP_UNDEF = 2'h3
    } eaw_step_e;
    localparam logic [2:0] SPACE_REG   = 3'h0;
    localparam logic [2:0] SPACE_DATA1 = 3'h1;
    localparam logic [2:0] SPACE_CODE1 = 3'h3;
    localparam logic [2:0] SPACE_CODE2 = 3'h4;
    localparam logic [1:0] BYTE_STEP   = 2'h1;

    // response status codes
    localparam logic [1:0] ST_OK   = 2'h0;
    localparam logic [1:0] ST_ERR  = 2'h1;
    localparam logic [1:0] ST_PEND = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 4;
    localparam int RESP_LIMIT_NS  = 5000000;
    localparam int RESP_LIMIT_CYC = RESP_LIMIT_NS / CLK_PERIOD_NS;
    localparam int STORE_CYC_DEF  = 16;
    localparam int WIN_DEPTH_DEF  = 256;
    localparam logic [7:0] PEND_ID_DEF = 8'h01;

endpackage

// ===== hw/eaw_addr_step.sv
/*
 * post-access stepper for the 22-bit combined extended address.
 * purely combinational; the caller registers the result.
 */
module eaw_addr_step
    import eaw_pkg::*;
(
    input  wire logic [21:0] addr_in,
    input  wire logic [1:0]  mode,
    input  wire logic [1:0]  step,
    output logic      [21:0] addr_out
);

    // ------------------------------------------------------------
    // step across all 22 bits so carries reach the high bits
    // ------------------------------------------------------------
    always_comb begin
        case (mode)
            EAW_STEP_INC: addr_out = addr_in + {20'h00000, step};
            EAW_STEP_DEC: addr_out = addr_in - {20'h00000, step};
            default:      addr_out = addr_in;
        endcase
    end

endmodule

// ===== hw/eaw_win_mem.sv
/*
 * small word memory behind the physical address spaces.
 * per-byte write enables, read data registered one cycle later.
 * assumes one write or read per cycle from the owning block.
 */
module eaw_win_mem #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          wr_en,
    input  wire logic [1:0]    byte_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [15:0]   wdata,
    output logic      [15:0]   rdata
);

    logic [15:0] mem_ff [DEPTH];
    logic [15:0] rdata_ff;

    if ((1 << AW) != DEPTH) begin : g_bad_depth
        $error("eaw_win_mem: DEPTH must equal 2**AW");
    end

    // ------------------------------------------------------------
    // byte lane writes and registered read in one process
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        for (int b = 0; b < 2; b++) begin
            if (wr_en && byte_en[b]) begin
                mem_ff[addr][8*b +: 8] <= wdata[8*b +: 8];
            end
        end
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= mem_ff[addr];
        end
    end

    assign rdata = rdata_ff;

endmodule

// ===== hw/eaw_ext_addr_regs.sv
/*
 * extended address window register set: two copies of the
 * configuration / low address / access window trio plus the
 * last response replay register.
 * assumes deframed request packets from a packet layer on the
 * same clock, and that layer frames and checks the responses.
 */
// Contract
// - read step field: hold, increment, decrement
// - write step field: hold, increment, decrement
// - space select chooses one of eight spaces
// - step size is unsigned step amount
// - byte transfers use only low byte
// - configuration bit six is reserved
// - six high bits join low register
// - low register holds value as written
// - register space maps low 256 addresses
// - window read returns addressed location
// - window write stores to writable location
// - window write answers zero unless pending
// - automatic and general register sets exist
// - replay read returns whole last response
// - replay does not create new response
// - execution error leaves address unchanged
// - out of field access gives error
// - slow store raises pending flag
// - soft reset aborts window transfers
module eaw_ext_addr_regs
    import eaw_pkg::*;
#(
    parameter int         WIN_DEPTH = eaw_pkg::WIN_DEPTH_DEF,
    parameter int         STORE_CYC = eaw_pkg::STORE_CYC_DEF,
    parameter int         LIMIT_CYC = eaw_pkg::RESP_LIMIT_CYC,
    parameter logic [7:0] PEND_ID   = eaw_pkg::PEND_ID_DEF
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        soft_rst,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [7:0]  req_reg,
    input  wire logic [15:0] req_data,
    output logic             rsp_valid,
    output logic      [1:0]  rsp_status,
    output logic      [7:0]  rsp_reg,
    output logic      [15:0] rsp_data,
    output logic             store_busy
);
    import eaw_pkg::*;

    localparam int   AW       = $clog2(WIN_DEPTH);
    localparam logic PEND_NOW = (STORE_CYC > LIMIT_CYC);

    if (WIN_DEPTH < 2 || (WIN_DEPTH & (WIN_DEPTH - 1)) != 0 || WIN_DEPTH >= 4194304
        || STORE_CYC < 1) begin : g_bad_param
        $error("eaw_ext_addr_regs: unsupported WIN_DEPTH or STORE_CYC");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EAW_IDLE  = 2'b00,
        EAW_RD    = 2'b01,
        EAW_STORE = 2'b10
    } eaw_fsm_e;

    typedef struct packed {
        eaw_fsm_e         st;
        logic [1:0][15:0] cfg;
        logic [1:0][15:0] low;
        logic [31:0]      last;
        logic             rv;
        logic [1:0]       rs;
        logic [7:0]       rr;
        logic [15:0]      rd;
        logic             set;
        logic             bm;
        logic             wt;
        logic [31:0]      cnt;
    } eaw_state_s;

    eaw_state_s  s_ff;
    eaw_state_s  nxt_s;
    logic        acc;
    logic        wsel;
    logic        ssel;
    logic [15:0] wcfg;
    logic [21:0] waddr;
    logic [2:0]  space;
    logic [2:0]  sp_m1;
    logic        phys;
    logic        code;
    logic        in_rng;
    logic        bmode;
    logic        ok;
    logic [1:0]  smode;
    logic [21:0] step_addr;
    logic        reg_hit;
    logic [15:0] reg_val;
    logic        mem_we;
    logic [1:0]  mem_be;
    logic [15:0] mem_rd;
    logic        go;
    logic [1:0]  gs;
    logic [15:0] gd;

    // ------------------------------------------------------------
    // request decode and selected window
    // ------------------------------------------------------------
    assign req_ready  = (s_ff.st == EAW_IDLE) && !soft_rst;
    assign acc        = req_valid && req_ready;
    // general set for 0x0e..0x10, automatic set otherwise
    assign wsel  = (req_reg == REG_CFG_GEN) || (req_reg == REG_LOW_GEN)
                   || (req_reg == REG_WIN_GEN);
    assign wcfg  = s_ff.cfg[wsel];
    assign waddr = {wcfg[HIADDR_HI:0], s_ff.low[wsel]};
    assign space = wcfg[SPACE_HI:SPACE_LO];
    assign sp_m1 = space - 3'h1;
    assign phys  = (space >= SPACE_DATA1) && (space <= SPACE_CODE2);
    assign code  = (space == SPACE_CODE1) || (space == SPACE_CODE2);
    assign in_rng = waddr < 22'(WIN_DEPTH);
    assign bmode = phys && (wcfg[STEP_HI:STEP_LO] == BYTE_STEP);
    assign ok    = phys && in_rng;

    // stepper works on the set of the access being finished
    assign ssel  = (s_ff.st == EAW_RD) ? s_ff.set : wsel;
    assign smode = (s_ff.st == EAW_IDLE && req_write)
                   ? s_ff.cfg[ssel][WSTEP_HI:WSTEP_LO]
                   : s_ff.cfg[ssel][RSTEP_HI:RSTEP_LO];

    eaw_addr_step u_step (
        .addr_in  ({s_ff.cfg[ssel][HIADDR_HI:0], s_ff.low[ssel]}),
        .mode     (smode),
        .step     (s_ff.cfg[ssel][STEP_HI:STEP_LO]),
        .addr_out (step_addr)
    );

    eaw_win_mem #(
        .DEPTH (4 * WIN_DEPTH),
        .AW    (AW + 2)
    ) u_mem (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (mem_we),
        .byte_en (mem_be),
        .addr    ({sp_m1[1:0], waddr[AW-1:0]}),
        .wdata   (req_data),
        .rdata   (mem_rd)
    );

    // register space view of this block's own registers
    always_comb begin
        reg_hit = 1'b1;
        case (waddr[7:0])
            REG_CFG_AUTO: reg_val = s_ff.cfg[0];
            REG_LOW_AUTO: reg_val = s_ff.low[0];
            REG_CFG_GEN:  reg_val = s_ff.cfg[1];
            REG_LOW_GEN:  reg_val = s_ff.low[1];
            default: begin
                reg_val = 16'h0000;
                reg_hit = 1'b0;
            end
        endcase
        if (waddr[21:8] != 14'h0000) begin
            reg_hit = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s  = s_ff;
        nxt_s.rv = 1'b0;
        go     = 1'b0;
        gs     = ST_ERR;
        gd     = 16'h0000;
        mem_we = 1'b0;
        mem_be = 2'b00;
        case (s_ff.st)
            EAW_IDLE: begin
                if (acc) begin
                    nxt_s.rr = req_reg;
                    go = 1'b1;
                    case (req_reg)
                        REG_CFG_AUTO, REG_CFG_GEN: begin
                            gs = ST_OK;
                            if (req_write) begin
                                nxt_s.cfg[wsel] = req_data & ~RSVD_MASK;
                                gd = req_data & ~RSVD_MASK;
                            end else begin
                                gd = wcfg;
                            end
                        end
                        REG_LOW_AUTO, REG_LOW_GEN: begin
                            gs = ST_OK;
                            if (req_write) begin
                                nxt_s.low[wsel] = req_data;
                                gd = req_data;
                            end else begin
                                gd = s_ff.low[wsel];
                            end
                        end
                        REG_WIN_AUTO, REG_WIN_GEN: begin
                            if (ok && req_write) begin
                                mem_we = 1'b1;
                                mem_be = bmode ? 2'b01 : 2'b11;
                                nxt_s.cfg[wsel][HIADDR_HI:0] = step_addr[21:16];
                                nxt_s.low[wsel] = step_addr[15:0];
                                if (code) begin
                                    nxt_s.st  = EAW_STORE;
                                    nxt_s.cnt = 32'(STORE_CYC);
                                    nxt_s.wt  = !PEND_NOW;
                                    go = PEND_NOW;
                                    gs = ST_PEND;
                                    gd = {PEND_ID, 8'h00};
                                end else begin
                                    gs = ST_OK;
                                end
                            end else if (ok) begin
                                go = 1'b0;
                                nxt_s.st  = EAW_RD;
                                nxt_s.set = wsel;
                                nxt_s.bm  = bmode;
                            end else if (space == SPACE_REG && !req_write && reg_hit) begin
                                gs = ST_OK;
                                gd = reg_val;
                                nxt_s.cfg[wsel][HIADDR_HI:0] = step_addr[21:16];
                                nxt_s.low[wsel] = step_addr[15:0];
                            end
                            // anything else: error, address untouched
                        end
                        REG_LAST: begin
                            if (!req_write) begin
                                go = 1'b0;
                                nxt_s.rv = 1'b1;
                                nxt_s.rs = s_ff.last[25:24];
                                nxt_s.rr = s_ff.last[23:16];
                                nxt_s.rd = s_ff.last[15:0];
                            end
                        end
                        default: ;
                    endcase
                end
            end
            EAW_RD: begin
                go = 1'b1;
                gs = ST_OK;
                gd = s_ff.bm ? {8'h00, mem_rd[7:0]} : mem_rd;
                nxt_s.cfg[s_ff.set][HIADDR_HI:0] = step_addr[21:16];
                nxt_s.low[s_ff.set] = step_addr[15:0];
                nxt_s.st = EAW_IDLE;
            end
            EAW_STORE: begin
                nxt_s.cnt = s_ff.cnt - 32'h1;
                if (s_ff.cnt == 32'h1) begin
                    nxt_s.st = EAW_IDLE;
                    nxt_s.wt = 1'b0;
                    go = s_ff.wt;
                    gs = ST_OK;
                end
            end
            default: nxt_s.st = EAW_IDLE;
        endcase
        // every fresh response is kept for replay
        if (go) begin
            nxt_s.rv   = 1'b1;
            nxt_s.rs   = gs;
            nxt_s.rd   = gd;
            nxt_s.last = {6'h00, gs, nxt_s.rr, gd};
        end
        // soft reset drops any transfer in flight
        if (soft_rst) begin
            nxt_s.st  = EAW_IDLE;
            nxt_s.cnt = 32'h0;
            nxt_s.wt  = 1'b0;
            nxt_s.rv  = 1'b0;
            nxt_s.cfg = {CFG_RESET, CFG_RESET};
            nxt_s.low = {LOW_RESET, LOW_RESET};
            nxt_s.last = s_ff.last;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_ff <= '{st: EAW_IDLE, cfg: {CFG_RESET, CFG_RESET},
                      low: {LOW_RESET, LOW_RESET}, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rsp_valid  = s_ff.rv;
    assign rsp_status = s_ff.rs;
    assign rsp_reg    = s_ff.rr;
    assign rsp_data   = s_ff.rd;
    assign store_busy = (s_ff.st == EAW_STORE);

    // ------------------------------------------------------------
    // assertions on the general set, replay reads and pending stores
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [21:0] gen_a;
    logic        win1;
    assign gen_a = {s_ff.cfg[1][HIADDR_HI:0], s_ff.low[1]};
    assign win1  = acc && (req_reg == REG_WIN_GEN);

    AST_READ_INC: assert property (
        win1 && !req_write && ok && wcfg[RSTEP_HI:RSTEP_LO] == EAW_STEP_INC
        |-> ##2 gen_a == $past(gen_a, 2) + {20'h00000, $past(wcfg[STEP_HI:STEP_LO], 2)})
        else $error("read did not post-increment the address");
    AST_WRITE_DEC: assert property (
        win1 && req_write && ok && wcfg[WSTEP_HI:WSTEP_LO] == EAW_STEP_DEC
        |=> gen_a == $past(gen_a) - {20'h00000, $past(wcfg[STEP_HI:STEP_LO])})
        else $error("write did not post-decrement the address");
    AST_UNDEF_HOLD: assert property (
        win1 && ok && smode == EAW_STEP_UNDEF
        |=> $stable(gen_a) ##1 ($past(req_write, 2) || $stable(gen_a)))
        else $error("undefined step mode moved the address");
    AST_OOR_ERR: assert property (
        win1 && phys && !in_rng
        |=> rsp_valid && rsp_status == ST_ERR && rsp_data == 16'h0000)
        else $error("out of range access not rejected");
    AST_ERR_HOLD: assert property (
        win1 && !phys && space != SPACE_REG |=> $stable(gen_a))
        else $error("error access changed the address");
    AST_WR_ZERO: assert property (
        win1 && req_write && ok && !code
        |=> rsp_valid && rsp_status == ST_OK && rsp_data == 16'h0000)
        else $error("window write answer not zero");
    AST_REPLAY: assert property (
        acc && req_reg == REG_LAST && !req_write
        |=> rsp_valid && {rsp_status, rsp_reg, rsp_data} == $past(s_ff.last[25:0])
            && $stable(s_ff.last))
        else $error("replay did not resend the stored response");
    AST_LOW_WR: assert property (
        acc && req_write && req_reg == REG_LOW_GEN |=> s_ff.low[1] == $past(req_data))
        else $error("low address not stored as written");
    AST_PEND: assert property (
        acc && req_write && (req_reg == REG_WIN_AUTO || req_reg == REG_WIN_GEN)
        && ok && code && PEND_NOW |=> rsp_valid && rsp_status == ST_PEND && store_busy)
        else $error("slow store did not raise pending");
    AST_SOFT: assert property (
        soft_rst |=> s_ff.st == EAW_IDLE && !rsp_valid && gen_a == 22'h000000)
        else $error("soft reset did not abort the transfer");

    COV_WIN_READ: cover property (win1 && !req_write && ok ##2 rsp_valid);
    COV_STORE:    cover property (store_busy ##1 !store_busy);
    COV_REPLAY:   cover property (acc && req_reg == REG_LAST && !req_write);

endmodule

// ===== dv/eaw_host_model.sv
/*
 * host side of the command port: issues one request at a time
 * and collects the matching response.
 * assumes the block answers through rsp_valid within 64 cycles.
 */
module eaw_host_model (
    input  wire logic        sys_clk,
    input  wire logic        req_ready,
    input  wire logic        rsp_valid,
    input  wire logic [1:0]  rsp_status,
    input  wire logic [7:0]  rsp_reg,
    input  wire logic [15:0] rsp_data,
    output logic             req_valid,
    output logic             req_write,
    output logic      [7:0]  req_reg,
    output logic      [15:0] req_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle request lines at time zero
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_reg   = 8'h00;
        req_data  = 16'h0000;
    end

    // --------------------------------------------------------
    // one transfer: hold until taken, then wait for the answer
    // --------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] rg, input logic [15:0] wd,
                        output logic [25:0] got, output bit ok);
        int n;
        ok  = 1'b0;
        got = 26'h0;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_reg   = rg;
        req_data  = wd;
        for (n = 0; n < 64 && !ok; n++) begin
            #1;
            if (req_ready === 1'b1) ok = 1'b1;
            else @(negedge sys_clk);
        end
        if (ok) begin
            @(posedge sys_clk);
            @(negedge sys_clk);
            // released lines show the inverse, never the old value
            req_valid = 1'b0;
            req_write = ~wr;
            req_reg   = ~rg;
            req_data  = ~wd;
            ok = 1'b0;
            for (n = 0; n < 64 && !ok; n++) begin
                if (rsp_valid === 1'b1) begin
                    ok  = 1'b1;
                    got = {rsp_status, rsp_reg, rsp_data};
                end else begin
                    @(negedge sys_clk);
                end
            end
        end
    endtask
endmodule

// ===== dv/tb.sv
/*
 * self-checking bench for the extended address window registers:
 * a queue-free reference model predicts every response.
 * assumes the host model in eaw_host_model and a 250 MHz clock.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import eaw_pkg::*;

    localparam int         WIN   = 16;
    localparam int         STORE = 6;
    localparam int         LIMIT = 4;
    localparam logic [7:0] PEND  = 8'h5a; // arbitrary pending tag

    logic        sys_clk, rst, soft_rst, req_valid, req_ready, req_write;
    logic [7:0]  req_reg, rsp_reg;
    logic [15:0] req_data, rsp_data;
    logic        rsp_valid, store_busy;
    logic [1:0]  rsp_status;
    int          error_cnt, comparisons;
    logic [15:0] m_cfg [2];
    logic [15:0] m_low [2];
    logic [15:0] m_mem [int];
    logic [25:0] m_last;
    logic [15:0] rnd;

    eaw_ext_addr_regs #(.WIN_DEPTH(WIN), .STORE_CYC(STORE), .LIMIT_CYC(LIMIT),
        .PEND_ID(PEND)) i_eaw_ext_addr_regs (
        .sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_reg(req_reg),
        .req_data(req_data), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
        .rsp_reg(rsp_reg), .rsp_data(rsp_data), .store_busy(store_busy));

    eaw_host_model i_eaw_host_model (
        .sys_clk(sys_clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_status(rsp_status), .rsp_reg(rsp_reg), .rsp_data(rsp_data),
        .req_valid(req_valid), .req_write(req_write), .req_reg(req_reg),
        .req_data(req_data));

    // free running clock
    always #2 sys_clk = ~sys_clk;

    // --------------------------------------------------------
    // reference model of one request
    // --------------------------------------------------------
    task automatic model_op(input logic wr, input logic [7:0] rg, input logic [15:0] wd,
                            output logic [25:0] e);
        int s, k;
        logic [21:0] a;
        logic [2:0]  sp;
        logic [1:0]  md, st, status;
        logic [15:0] d;
        status = ST_ERR;
        d = 16'h0000;
        s = (rg >= REG_CFG_GEN) ? 1 : 0;
        case (rg)
            REG_CFG_AUTO, REG_CFG_GEN: begin
                status = ST_OK;
                if (wr) m_cfg[s] = wd & ~RSVD_MASK;
                d = m_cfg[s];
            end
            REG_LOW_AUTO, REG_LOW_GEN: begin
                status = ST_OK;
                if (wr) m_low[s] = wd;
                d = m_low[s];
            end
            REG_LAST: if (!wr) begin
                e = m_last;
                return;
            end
            REG_WIN_AUTO, REG_WIN_GEN: begin
                a  = {m_cfg[s][5:0], m_low[s]};
                sp = m_cfg[s][11:9];
                st = m_cfg[s][8:7];
                md = wr ? m_cfg[s][13:12] : m_cfg[s][15:14];
                if (sp == SPACE_REG && !wr && (a == 9 || a == 10 || a == 14 || a == 15)) begin
                    status = ST_OK;
                    d = (a == 9 || a == 14) ? m_cfg[a[2]] : m_low[a[2]];
                end else if (sp >= 3'h1 && sp <= 3'h4 && a < WIN) begin
                    status = ST_OK;
                    k = int'(sp) * WIN + int'(a);
                    if (!wr) begin
                        d = (st == BYTE_STEP) ? {8'h00, m_mem[k][7:0]} : m_mem[k];
                    end else begin
                        m_mem[k] = (st == BYTE_STEP) ? {m_mem[k][15:8], wd[7:0]} : wd;
                        if (sp >= SPACE_CODE1 && STORE > LIMIT) begin
                            status = ST_PEND;
                            d = {PEND, 8'h00};
                        end
                    end
                end
                if (status != ST_ERR) begin
                    if (md == EAW_STEP_INC) a = a + 22'(st);
                    else if (md == EAW_STEP_DEC) a = a - 22'(st);
                    m_cfg[s][5:0] = a[21:16];
                    m_low[s] = a[15:0];
                end
            end
            default: ;
        endcase
        e = {status, rg, d};
        m_last = e;
    endtask

    // one request through the host, compared with the model
    task automatic do_op(input logic wr, input logic [7:0] rg, input logic [15:0] wd);
        logic [25:0] got, e;
        bit ok;
        i_eaw_host_model.xfer(wr, rg, wd, got, ok);
        if (!ok) begin
            error_cnt++;
            report_and_stop();
        end else begin
            model_op(wr, rg, wd, e);
            comparisons++;
            if (got !== e) begin
                $display("unexpected at %0t: got %h expected %h", $time, got, e);
                error_cnt++;
            end
        end
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        logic [7:0] tbl [8];
        logic [7:0] base;
        int i, a, sp;
        tbl = '{8'h09, 8'h0a, 8'h0e, 8'h0f, 8'h11, 8'h13, 8'h00, 8'hff};
        sys_clk = 1'b0;
        rst = 1'b1;
        soft_rst = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        rnd = 16'h0017;
        m_cfg = '{CFG_RESET, CFG_RESET};
        m_low = '{LOW_RESET, LOW_RESET};
        m_last = 26'h0;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        // reset values of the configuration and low registers, three unmapped ones and a replay of the 0x11 answer
        for (i = 0; i < 8; i++) do_op(1'b0, tbl[i], 16'h0000);
        // fill every word of the four physical spaces
        for (sp = 1; sp <= 4; sp++) begin
            do_op(1'b1, REG_CFG_AUTO, 16'(sp << 9));
            for (a = 0; a < WIN; a++) begin
                rnd = lfsr_next(rnd);
                do_op(1'b1, REG_LOW_AUTO, 16'(a));
                do_op(1'b1, REG_WIN_AUTO, rnd);
            end
        end
        // random mix of configurations, window traffic and replays
        for (i = 0; i < 300; i++) begin
            rnd = lfsr_next(rnd);
            base = rnd[0] ? REG_CFG_GEN : REG_CFG_AUTO;
            a = int'(rnd[3:1]);
            rnd = lfsr_next(rnd);
            case (a)
                0: do_op(1'b1, base, (rnd[15:13] == 3'h0) ? rnd : rnd & 16'hffc0);
                1: do_op(1'b1, base + 8'h01, {11'h0, rnd[4:0]});
                2, 3: do_op(1'b0, base + 8'h02, rnd);
                4, 5: do_op(1'b1, base + 8'h02, rnd);
                6: do_op(1'b0, REG_LAST, rnd);
                default: do_op(rnd[0], tbl[rnd[3:1]], rnd);
            endcase
        end
        // borrow out of the low register into the high bits
        do_op(1'b1, REG_CFG_GEN, 16'h8300);
        do_op(1'b1, REG_LOW_GEN, 16'h0001);
        do_op(1'b0, REG_WIN_GEN, 16'h0000);
        do_op(1'b0, REG_CFG_GEN, 16'h0000);
        // soft reset in the middle of a code store
        do_op(1'b1, REG_CFG_GEN, 16'h0600);
        do_op(1'b1, REG_LOW_GEN, 16'h0000);
        do_op(1'b1, REG_WIN_GEN, 16'hbeef);
        comparisons++;
        if (store_busy !== 1'b1) begin
            $display("unexpected at %0t: got %h expected %h", $time, store_busy, 1'b1);
            error_cnt++;
        end
        @(negedge sys_clk);
        soft_rst = 1'b1;
        @(negedge sys_clk);
        soft_rst = 1'b0;
        m_cfg = '{16'h0000, 16'h0000};
        m_low = '{16'h0000, 16'h0000};
        comparisons++;
        if (store_busy !== 1'b0) begin
            $display("unexpected at %0t: got %h expected %h", $time, store_busy, 1'b0);
            error_cnt++;
        end
        do_op(1'b0, REG_LAST, 16'h0000);
        do_op(1'b0, REG_CFG_GEN, 16'h0000);
        do_op(1'b0, REG_LOW_AUTO, 16'h0000);
        report_and_stop();
    end
endmodule
